// ---- logic/sbm_byte_master.sv ----
// two-wire serial bus byte access master with avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module sbm_byte_master (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [9:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_irq,
	input  wire logic        i_scl_in,
	output logic             o_scl_out,
	output logic             o_scl_oe,
	input  wire logic        i_sda_in,
	output logic             o_sda_out,
	output logic             o_sda_oe
);

	logic                 wait_q, wait_d;
	logic [31:0]          rdata_q, rdata_d;
	logic                 line_low_q;
	logic                 scl_m_q, scl_s_q, sda_m_q, sda_s_q;
	logic [7:0]           payload_q, payload_d;
	logic [7:0]           offset_q, offset_d;
	sbm_pkg::sbm_target_t target_q, target_d;
	logic                 short_q, short_d;
	logic                 fast_q, fast_d;
	logic                 err_q, err_d;
	logic                 busy_q, busy_d;
	sbm_pkg::sbm_irq_t    sts_q, sts_d, mask_q, mask_d;
	logic                 irq_q, irq_d;
	sbm_pkg::sbm_state_t  state_q, state_d;
	logic [1:0]           qtr_q, qtr_d;
	logic [3:0]           bit_q, bit_d;
	logic [7:0]           shift_q, shift_d;
	logic                 rx_q, rx_d;
	logic                 nack_q, nack_d;
	logic [1:0]           ph_q, ph_d;
	logic [8:0]           cnt_q, cnt_d;
	logic                 scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
	logic                 wr_acc, rd_acc, wr_lane0;
	logic [7:0]           idx;
	logic [8:0]           qtr_lim;
	logic                 stretch, adv;
	sbm_pkg::sbm_ctrl_t   ctrl_view;

	// pin synchronisers, two stages each
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			scl_m_q <= i_scl_in;
			scl_s_q <= scl_m_q;
			sda_m_q <= i_sda_in;
			sda_s_q <= sda_m_q;
		end
	end

	// access decode: request answered one cycle after it is seen
	assign idx      = i_avs_address[9:2];
	assign wr_acc   = i_avs_write && !wait_q;
	assign rd_acc   = i_avs_read && !wait_q;
	assign wr_lane0 = wr_acc && i_avs_byteenable[0];

	// control view for readback
	always_comb begin
		ctrl_view                        = '0;
		ctrl_view.short_protocol_select  = short_q;
		ctrl_view.request_in_flight_flag = busy_q;
		ctrl_view.fast_clock_test_bit    = fast_q;
		ctrl_view.access_error_flag      = err_q;
	end

	// bus slave next values: one wait cycle, readback, unmapped reads zero
	always_comb begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if ((i_avs_read || i_avs_write) && wait_q) begin
			wait_d  = 1'b0;
			rdata_d = '0;
			case (idx)
				sbm_pkg::IDX_PAYLOAD:    rdata_d[7:0] = payload_q;
				sbm_pkg::IDX_OFFSET:     rdata_d[7:0] = offset_q;
				sbm_pkg::IDX_TARGET:     rdata_d[7:0] = target_q;
				sbm_pkg::IDX_CTRL:       rdata_d[7:0] = ctrl_view;
				sbm_pkg::IDX_IRQ_STATUS: rdata_d[1:0] = sts_q;
				sbm_pkg::IDX_IRQ_MASK:   rdata_d[1:0] = mask_q;
				default:                 rdata_d      = '0;
			endcase
		end
	end

	// bus slave registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wait_q     <= 1'b1;
			rdata_q    <= '0;
			line_low_q <= 1'b0;
		end else begin
			wait_q     <= wait_d;
			rdata_q    <= rdata_d;
			line_low_q <= 1'b0;
		end
	end

	// quarter-bit pacing; a slave holding the clock low keeps the count at zero
	assign qtr_lim = (fast_q ? sbm_pkg::QTR_TEST : sbm_pkg::QTR_NORMAL) - 9'h001;
	assign stretch = busy_q && !scl_oe_q && !scl_s_q;
	assign adv     = busy_q && !stretch && (cnt_q >= qtr_lim);

	// registers, sequencer and event next values
	always_comb begin
		payload_d = payload_q;
		offset_d  = offset_q;
		target_d  = target_q;
		short_d   = short_q;
		fast_d    = fast_q;
		err_d     = err_q;
		busy_d    = busy_q;
		sts_d     = sts_q;
		mask_d    = mask_q;
		state_d   = state_q;
		qtr_d     = qtr_q;
		bit_d     = bit_q;
		shift_d   = shift_q;
		rx_d      = rx_q;
		nack_d    = nack_q;
		ph_d      = ph_q;
		scl_oe_d  = scl_oe_q;
		sda_oe_d  = sda_oe_q;
		cnt_d     = (busy_q && !stretch && !adv) ? cnt_q + 9'h001 : '0;

		// software writes; event set below overrides clears
		if (wr_lane0) begin
			case (idx)
				sbm_pkg::IDX_PAYLOAD: payload_d = i_avs_writedata[7:0];
				sbm_pkg::IDX_OFFSET:  offset_d  = i_avs_writedata[7:0];
				sbm_pkg::IDX_TARGET: begin
					if (!busy_q) begin
						target_d = i_avs_writedata[7:0];
						busy_d   = 1'b1;
						state_d  = sbm_pkg::ST_START;
						qtr_d    = 2'h0;
						bit_d    = 4'h0;
						ph_d     = sbm_pkg::PH_ADDR_FIRST;
						rx_d     = 1'b0;
						nack_d   = 1'b0;
						cnt_d    = '0;
						// direction goes out first only in short mode
						shift_d  = {i_avs_writedata[7:1], short_q & i_avs_writedata[0]};
					end
				end
				sbm_pkg::IDX_CTRL: begin
					short_d = i_avs_writedata[7];
					fast_d  = i_avs_writedata[2];
					if (i_avs_writedata[1]) begin
						err_d = 1'b0;
					end
				end
				sbm_pkg::IDX_IRQ_STATUS: sts_d  = sts_q & ~i_avs_writedata[1:0];
				sbm_pkg::IDX_IRQ_MASK:   mask_d = i_avs_writedata[1:0];
				default: begin
				end
			endcase
		end

		// serial sequencer, one step per quarter bit
		if (adv) begin
			qtr_d = qtr_q + 2'h1;
			case (state_q)
				sbm_pkg::ST_START: begin
					case (qtr_q)
						2'h0: sda_oe_d = 1'b0;
						2'h1: scl_oe_d = 1'b0;
						2'h2: sda_oe_d = 1'b1;
						default: begin
							scl_oe_d = 1'b1;
							state_d  = sbm_pkg::ST_BIT;
							bit_d    = 4'h0;
						end
					endcase
				end
				sbm_pkg::ST_BIT: begin
					case (qtr_q)
						// data bit, or release for acknowledge; not-acknowledge on reads
						2'h0: sda_oe_d = !rx_q && (bit_q != sbm_pkg::LAST_BIT) && !shift_q[7];
						2'h1: scl_oe_d = 1'b0;
						2'h2: begin
							if (bit_q != sbm_pkg::LAST_BIT) begin
								shift_d = {shift_q[6:0], rx_q & sda_s_q};
							end else if (!rx_q) begin
								nack_d = sda_s_q;
							end
						end
						default: begin
							scl_oe_d = 1'b1;
							bit_d    = bit_q + 4'h1;
							if (bit_q == sbm_pkg::LAST_BIT) begin
								bit_d   = 4'h0;
								state_d = sbm_pkg::ST_BIT;
								if (nack_q) begin
									err_d   = 1'b1;
									sts_d.error_event = 1'b1;
									state_d = sbm_pkg::ST_STOP;
								end else begin
									case (ph_q)
										sbm_pkg::PH_ADDR_FIRST: begin
											if (short_q) begin
												ph_d    = sbm_pkg::PH_DATA;
												rx_d    = target_q.direction_select;
												shift_d = payload_q;
											end else begin
												ph_d    = sbm_pkg::PH_OFFSET;
												shift_d = offset_q;
											end
										end
										sbm_pkg::PH_OFFSET: begin
											if (target_q.direction_select) begin
												ph_d    = sbm_pkg::PH_ADDR_READ;
												state_d = sbm_pkg::ST_START;
												shift_d = {target_q.target_device_id, 1'b1};
											end else begin
												ph_d    = sbm_pkg::PH_DATA;
												shift_d = payload_q;
											end
										end
										sbm_pkg::PH_ADDR_READ: begin
											ph_d = sbm_pkg::PH_DATA;
											rx_d = 1'b1;
										end
										default: begin
											state_d = sbm_pkg::ST_STOP;
											if (rx_q) begin
												payload_d = shift_q;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
				sbm_pkg::ST_STOP: begin
					case (qtr_q)
						2'h0: sda_oe_d = 1'b1;
						2'h1: scl_oe_d = 1'b0;
						2'h2: sda_oe_d = 1'b0;
						default: begin
							state_d = sbm_pkg::ST_IDLE;
							busy_d  = 1'b0;
							sts_d.done_event = 1'b1;
						end
					endcase
				end
				default: begin
					state_d = sbm_pkg::ST_IDLE;
					busy_d  = 1'b0;
				end
			endcase
		end
		irq_d = |(sts_d & mask_d);
	end

	// registers and sequencer state
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			payload_q <= sbm_pkg::RST_BYTE;
			offset_q  <= sbm_pkg::RST_BYTE;
			target_q  <= sbm_pkg::RST_BYTE;
			short_q   <= 1'b0;
			fast_q    <= 1'b0;
			err_q     <= 1'b0;
			busy_q    <= 1'b0;
			sts_q     <= sbm_pkg::RST_IRQ;
			mask_q    <= sbm_pkg::RST_IRQ;
			irq_q     <= 1'b0;
			state_q   <= sbm_pkg::ST_IDLE;
			qtr_q     <= 2'h0;
			bit_q     <= 4'h0;
			shift_q   <= 8'h00;
			rx_q      <= 1'b0;
			nack_q    <= 1'b0;
			ph_q      <= sbm_pkg::PH_ADDR_FIRST;
			cnt_q     <= '0;
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
		end else begin
			payload_q <= payload_d;
			offset_q  <= offset_d;
			target_q  <= target_d;
			short_q   <= short_d;
			fast_q    <= fast_d;
			err_q     <= err_d;
			busy_q    <= busy_d;
			sts_q     <= sts_d;
			mask_q    <= mask_d;
			irq_q     <= irq_d;
			state_q   <= state_d;
			qtr_q     <= qtr_d;
			bit_q     <= bit_d;
			shift_q   <= shift_d;
			rx_q      <= rx_d;
			nack_q    <= nack_d;
			ph_q      <= ph_d;
			cnt_q     <= cnt_d;
			scl_oe_q  <= scl_oe_d;
			sda_oe_q  <= sda_oe_d;
		end
	end

	// outputs straight from flip-flops; the lines are only ever pulled low
	assign o_avs_readdata    = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign o_irq             = irq_q;
	assign o_scl_out         = line_low_q;
	assign o_scl_oe          = scl_oe_q;
	assign o_sda_out         = line_low_q;
	assign o_sda_oe          = sda_oe_q;

endmodule // sbm_byte_master

// ---- pkg/sbm_pkg.sv ----
// constants, register layouts and states of the serial bus byte access master
package sbm_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_PAYLOAD    = 8'hb0;
	localparam logic [7:0] IDX_OFFSET     = 8'hb1;
	localparam logic [7:0] IDX_TARGET     = 8'hb2;
	localparam logic [7:0] IDX_CTRL       = 8'hb3;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hb4;
	localparam logic [7:0] IDX_IRQ_MASK   = 8'hb5;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_IRQ  = 2'h0;

	// control and status register layout
	typedef struct packed {
		logic       short_protocol_select;
		logic       rsvd6;
		logic       request_in_flight_flag;
		logic [1:0] rsvd43;
		logic       fast_clock_test_bit;
		logic       access_error_flag;
		logic       rsvd0;
	} sbm_ctrl_t;

	// target device and direction register layout
	typedef struct packed {
		logic [6:0] target_device_id;
		logic       direction_select;
	} sbm_target_t;

	// interrupt status and mask layout, bits 1..0
	typedef struct packed {
		logic error_event;
		logic done_event;
	} sbm_irq_t;

	// serial clock timing, each bit split into four quarters
	localparam int CLK_PERIOD_NS       = 10;
	localparam int SCL_PERIOD_NORMAL_NS = 10000;
	localparam int SCL_PERIOD_TEST_NS   = 2500;
	localparam int QTR_DIV              = 4 * CLK_PERIOD_NS;
	localparam logic [8:0] QTR_NORMAL   = 9'((SCL_PERIOD_NORMAL_NS + QTR_DIV - 1) / QTR_DIV);
	localparam logic [8:0] QTR_TEST     = 9'((SCL_PERIOD_TEST_NS + QTR_DIV - 1) / QTR_DIV);

	// byte phases of one transfer
	localparam logic [1:0] PH_ADDR_FIRST = 2'h0;
	localparam logic [1:0] PH_OFFSET     = 2'h1;
	localparam logic [1:0] PH_ADDR_READ  = 2'h2;
	localparam logic [1:0] PH_DATA       = 2'h3;
	localparam logic [3:0] LAST_BIT      = 4'h8;

	// bus sequencer states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_BIT   = 4'b0100,
		ST_STOP  = 4'b1000
	} sbm_state_t;

endpackage

// ---- verif/sbm_chk.sv ----
// port assertions for the byte master
`timescale 1ns/1ps
module sbm_chk (
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic [9:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0]  i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_irq,
	input wire logic        i_scl_in,
	input wire logic        o_scl_out,
	input wire logic        o_scl_oe,
	input wire logic        i_sda_in,
	input wire logic        o_sda_out,
	input wire logic        o_sda_oe
);
	logic [11:0] idle_q, idle_d, gap_q, gap_d;
	logic        scl_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// span of released bus and of steady clock pin
	always_comb begin
		idle_d = (o_scl_oe || o_sda_oe) ? 12'h0 : idle_q + 12'(idle_q != 12'hfff);
		gap_d  = (o_scl_oe != scl_q) ? 12'h0 : gap_q + 12'(gap_q != 12'hfff);
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			idle_q <= 12'hfff;
			gap_q  <= 12'hfff;
			scl_q  <= 1'b0;
		end else begin
			idle_q <= idle_d;
			gap_q  <= gap_d;
			scl_q  <= o_scl_oe;
		end
	end
	property p_ans;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_ans: assert property (p_ans) else $error("no bus answer");
	property p_one;
		!o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_one: assert property (p_one) else $error("wait low too long");
	property p_unmap;
		i_avs_read && !o_avs_waitrequest && i_avs_address[9:2] > sbm_pkg::IDX_IRQ_MASK |-> o_avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_od;
		o_scl_oe || o_sda_oe |-> !(o_scl_out || o_sda_out);
	endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_start;
		i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address[9:2] == sbm_pkg::IDX_TARGET
			&& idle_q > 12'd1100 |-> ##[1:800] (o_sda_oe && !o_scl_oe);
	endproperty
	a_start: assert property (p_start) else $error("no start condition");
	// an error event may rise during the ack bit, but the data line is then released
	property p_irq;
		$rose(o_irq) |-> !o_sda_oe;
	endproperty
	a_irq: assert property (p_irq) else $error("irq with data line pulled");
	property p_gap;
		scl_q != o_scl_oe |-> gap_q > 12'd120;
	endproperty
	a_gap: assert property (p_gap) else $error("clock too fast");
	property p_pins;
		$changed(o_scl_oe) |-> $stable(o_sda_oe);
	endproperty
	a_pins: assert property (p_pins) else $error("both pins moved");
endmodule // sbm_chk
bind sbm_byte_master sbm_chk u_sbm_chk (.*);

// ---- verif/sbm_slave_model.sv ----
// behavioural two-wire slave: acks, records bytes, answers reads
`timescale 1ns/1ps
module sbm_slave_model #(
	parameter logic [6:0] DEV = 7'h50
) (
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_nak,
	input  wire logic [7:0] i_rdat,
	output logic            o_pull
);
	logic [7:0] sh, rx[64];
	logic       first = 0, rd = 0, act = 0;
	int         bc = 0, nb = 0;
	initial o_pull = 1'b0;
	// start or repeated start, then stop
	always @(negedge i_sda) if (i_scl) begin
		bc = 0;
		first = 1;
	end
	always @(posedge i_sda) if (i_scl) act = 0;
	// shift in on rising clock
	always @(posedge i_scl) begin
		if (bc < 8) sh = {sh[6:0], i_sda};
		bc++;
	end
	// ack, or read data, after falling clock; released line floats high
	always @(negedge i_scl) begin
		if (bc == 8 && first) begin
			rd = sh[0];
			act = sh[7:1] == DEV;
		end
		if (bc == 8 && !(act && rd && !first)) begin
			rx[nb] = sh;
			nb++;
		end
		if (bc == 9) begin
			if (rd && !first && i_sda) act = 0; // master nack ends the read
			bc = 0;
			first = 0;
		end
		if (bc == 8) o_pull = act && !i_nak && !(rd && !first);
		else o_pull = act && rd && !first && bc < 8 && !i_rdat[3'(7 - bc)];
	end
endmodule // sbm_slave_model

// ---- verif/sbm_byte_master_bench.sv ----
// self-checking bench: register tasks, slave model, mode sweep
`timescale 1ns/1ps
module sbm_byte_master_bench;
	localparam logic [6:0] DEV = 7'h50;
	logic        i_clk, i_reset_n, rd_r, wr_r, nak, pull, wreq, irq, scl_oe, sda_oe, s, d;
	logic [9:0]  adr;
	logic [31:0] wdat, rdata, q;
	logic [7:0]  rdat, pay, off;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe || pull);
	int          err_total = 0, compares = 0, seed, base;
	time         t0;
	sbm_byte_master u_sbm_byte_master (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(adr),
		.i_avs_read(rd_r), .i_avs_write(wr_r), .i_avs_writedata(wdat), .i_avs_byteenable(4'h1),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_irq(irq), .i_scl_in(scl), .o_scl_out(),
		.o_scl_oe(scl_oe), .i_sda_in(sda), .o_sda_out(), .o_sda_oe(sda_oe));
	sbm_slave_model #(.DEV(DEV)) u_sbm_slave_model (.i_scl(scl), .i_sda(sda), .i_nak(nak), .i_rdat(rdat),
		.o_pull(pull));
	initial begin
		i_clk = 0;
		forever #5 i_clk = !i_clk;
	end
	// one register access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
		int n = 0;
		adr <= {idx, 2'h0};
		wdat <= {24'h0, v};
		wr_r <= w;
		rd_r <= !w;
		do begin
			@(posedge i_clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (wreq !== 1'b0) chk({31'h0, wreq}, 32'h0);
		q = rdata;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 8'h0);
		chk(q, e);
	endtask
	task automatic ichk(input logic e);
		repeat (2) @(posedge i_clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// poll until the in-flight flag drops
	task automatic poll;
		int n = 0;
		do begin
			bus(1'b0, 8'hb3, 8'h0);
			n++;
		end while (q[5] !== 1'b0 && n < 5000);
		if (q[5] !== 1'b0) chk({31'h0, q[5]}, 32'h0);
	endtask
	function automatic logic [7:0] exp_byte(input logic sp, input logic dr, input int i);
		case ({sp, dr, i[1:0]})
			4'b0001, 4'b0101: return off;
			4'b0010, 4'b1001: return pay;
			4'b0110, 4'b1100: return {DEV, 1'b1};
			default: return {DEV, 1'b0};
		endcase
	endfunction
	function automatic int exp_cnt(input logic sp, input logic dr);
		return sp ? (dr ? 1 : 2) : 3;
	endfunction
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		test_done;
	end
	// reset, register defaults, then every protocol mode and a refused ack
	initial begin
		seed = 32'h3486;
		{i_reset_n, rd_r, wr_r, nak, adr, wdat, rdat} = '0;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		for (int k = 0; k < 8; k++) rchk(8'hb0 + 8'(k), 32'h0);
		bus(1'b1, 8'hb8, 8'hff);
		rchk(8'hb8, 32'h0);
		bus(1'b1, 8'hb5, 8'h03);
		$display("test reset values done");
		for (int m = 0; m < 5; m++) begin
			s = m[1];
			d = m[0];
			pay = 8'($random(seed));
			off = 8'($random(seed));
			nak <= (m == 4);
			rdat <= 8'($random(seed));
			// last mode runs at the normal serial clock rate
			bus(1'b1, 8'hb3, {s, 4'h0, m != 4, 2'h0});
			bus(1'b1, 8'hb0, pay);
			bus(1'b1, 8'hb1, off);
			base = u_sbm_slave_model.nb;
			bus(1'b1, 8'hb2, {DEV, d});
			t0 = $time;
			rchk(8'hb3, {24'h0, s, 2'h1, 2'h0, m != 4, 2'h0});
			poll;
			if (m < 4) begin
				chk(32'(u_sbm_slave_model.nb - base), 32'(exp_cnt(s, d)));
				for (int i = 0; i < exp_cnt(s, d); i++) begin
					chk(32'(u_sbm_slave_model.rx[base + i]), 32'(exp_byte(s, d, i)));
				end
				rchk(8'hb0, 32'(d ? rdat : pay));
			end else begin
				// refused address: start, nine bits and stop, 44 quarters at normal rate
				chk(32'(($time - t0) / (sbm_pkg::QTR_NORMAL * sbm_pkg::CLK_PERIOD_NS) >= 44), 32'h1);
				rchk(8'hb3, 32'h02);
				rchk(8'hb0, 32'(pay));
			end
			ichk(1'b1);
			bus(1'b1, 8'hb5, 8'h00);
			ichk(1'b0);
			bus(1'b1, 8'hb5, 8'h03);
			ichk(1'b1);
			bus(1'b1, 8'hb4, 8'h03);
			bus(1'b1, 8'hb3, 8'h02);
			ichk(1'b0);
			$display("test mode %0d done", m);
		end
		rchk(8'hb3, 32'h0);
		test_done;
	end
endmodule // sbm_byte_master_bench
